//--- core/homing_fsm.sv
/*
 Per-axis homing sequencer: searches end or home switches, calibrates the
 switching point and zeroes the position counter.
 Assumes synchronous switch inputs and a host that issues one command per cycle.
*/
`timescale 1ns/1ps
// Behaviour
// - Homing runs as a state machine started, stopped, polled by command code 13.
// - Automatic end-switch stop settings have no effect during homing.
// - Before first switch hit the axis moves at the search speed.
// - After hit, slowly leave switch, re-enter opposite way, zero at midpoint.
// - Calibration moves use the calibration speed.
// - Host selects mode; base values 1 to 8 are distinct procedures.
// - Mode 1 searches only the left end switch as reference.
// - Mode 2 finds right switch, then left; left is zero.
// - Mode 2 reports end switch distance in microsteps.
// - Mode 3 finds right, then left centre; reports right-to-centre distance.
// - Mode 4 finds left switch centre from both sides.
// - Adding 64 to modes 1 to 4 swaps left and right switches.
// - Mode 5 seeks home negative, reversing at the left limit.
// - Mode 6 seeks home positive, reversing at the right limit.
// - Mode 7 seeks home positive, ignores limits, zero at centre.
// - Mode 8 seeks home, ignores limits, zero at centre.
// - Adding 128 to modes 5 to 8 inverts home switch polarity.
module homing_fsm (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  homing_pkg::cmd_s                    cmd,
	input  wire logic [7:0]                     search_mode,
	input  wire logic [homing_pkg::SPEED_W-1:0] search_speed,
	input  wire logic [homing_pkg::SPEED_W-1:0] calib_speed,
	input  wire logic                           sw_left,
	input  wire logic                           sw_right,
	input  wire logic                           sw_home,
	output logic                                step_pulse,
	output logic                                dir_out,
	output logic                                busy,
	output logic                                done,
	output logic                                aborted,
	output logic                                mode_error,
	output logic [homing_pkg::POS_W-1:0]        position,
	output logic [homing_pkg::POS_W-1:0]        switch_distance,
	output homing_pkg::reply_s                  reply
);
	import homing_pkg::*;

	typedef enum logic [2:0] {IDLE, START, SEEK_FAR, SEEK, CAL_OUT, CAL_IN} state_e;

	function automatic logic [POS_W-1:0] midpoint(input logic [POS_W-1:0] a,
		input logic [POS_W-1:0] b);
		logic [POS_W:0] s;
		s = {a[POS_W-1], a} + {b[POS_W-1], b};
		return s[POS_W:1];
	endfunction

	function automatic logic [POS_W-1:0] distance(input logic [POS_W-1:0] a,
		input logic [POS_W-1:0] b);
		logic [POS_W-1:0] d;
		d = a - b;
		return d[POS_W-1] ? (~d + POS_ONE) : d;
	endfunction

	state_e             state_reg, state_next;
	logic [7:0]         mode_reg, mode_next;
	logic               dir_reg, dir_next;
	logic               fast_reg, fast_next;
	logic               step_reg, step_next;
	logic               busy_reg, busy_next;
	logic               done_reg, done_next;
	logic               abort_reg, abort_next;
	logic               err_reg, err_next;
	logic [POS_W-1:0]   pos_reg, pos_next;
	logic [POS_W-1:0]   p1_reg, p1_next;
	logic [POS_W-1:0]   far_reg, far_next;
	logic [POS_W-1:0]   dist_reg, dist_next;
	logic [POS_W-1:0]   ref_pt;
	reply_s             reply_reg, reply_next;
	sel_s               sel;
	logic               tick;
	logic [SPEED_W-1:0] cur_speed;
	logic               hit_cmd;
	logic               start_cmd;
	logic               stop_cmd;

	switch_pick u_pick (
		.mode     (mode_reg),
		.sw_left  (sw_left),
		.sw_right (sw_right),
		.sw_home  (sw_home),
		.sel      (sel)
	);

	// Speed follows the phase: fast until the target switch is hit, slow afterwards
	assign cur_speed = fast_reg ? search_speed : calib_speed;

	step_gen u_step (
		.clk   (clk),
		.rst_n (rst_n),
		.en    (state_reg inside {SEEK_FAR, SEEK, CAL_OUT, CAL_IN}),
		.speed (cur_speed),
		.tick  (tick)
	);

	always_comb
	begin
		hit_cmd   = cmd.valid && cmd.code == HOMING_CODE;
		start_cmd = hit_cmd && cmd.op == OP_START;
		stop_cmd  = hit_cmd && cmd.op == OP_STOP;
		ref_pt    = midpoint(p1_reg, pos_reg);
	end

	// End-switch auto-stop is not consulted here, so it cannot cut a search short
	always_comb
	begin
		state_next = state_reg;
		mode_next  = mode_reg;
		dir_next   = dir_reg;
		fast_next  = fast_reg;
		done_next  = done_reg;
		abort_next = abort_reg;
		err_next   = err_reg;
		p1_next    = p1_reg;
		far_next   = far_reg;
		dist_next  = dist_reg;
		pos_next   = pos_reg;
		step_next  = 1'b0;
		reply_next = '{valid: hit_cmd && cmd.op == OP_POLL, busy: busy_reg,
			done: done_reg, aborted: abort_reg};
		if (tick && state_reg != IDLE)
		begin
			step_next = 1'b1;
			pos_next  = dir_reg ? pos_reg + POS_ONE : pos_reg - POS_ONE;
		end
		case (state_reg)
			IDLE:
			begin
				if (start_cmd)
				begin
					mode_next  = search_mode;
					state_next = START;
					done_next  = 1'b0;
					abort_next = 1'b0;
					err_next   = 1'b0;
				end
			end
			START:
			begin
				fast_next = 1'b1;
				if (!sel.ok)
				begin
					state_next = IDLE;
					err_next   = 1'b1;
				end
				else if (sel.two_stage)
				begin
					state_next = SEEK_FAR;
					dir_next   = sel.dir_far;
				end
				else
				begin
					state_next = SEEK;
					dir_next   = sel.dir_tgt;
				end
			end
			SEEK_FAR:
			begin
				if (sel.far)
				begin
					far_next   = pos_reg;
					state_next = SEEK;
					dir_next   = sel.dir_tgt;
				end
			end
			SEEK:
			begin
				if (sel.target)
				begin
					p1_next    = pos_reg;
					fast_next  = 1'b0;
					state_next = CAL_OUT;
					// Centre modes cross the switch; edge modes back out of it
					dir_next   = sel.centre ? dir_reg : !dir_reg;
				end
				else if (sel.use_limit && sel.limit)
				begin
					dir_next = !sel.dir_tgt;
				end
			end
			CAL_OUT:
			begin
				if (!sel.target)
				begin
					if (!sel.centre)
					begin
						p1_next = pos_reg;
					end
					state_next = CAL_IN;
					dir_next   = !dir_reg;
				end
			end
			CAL_IN:
			begin
				if (sel.target)
				begin
					state_next = IDLE;
					step_next  = 1'b0;
					pos_next   = pos_reg - ref_pt;
					done_next  = 1'b1;
					if (sel.two_stage)
					begin
						dist_next = distance(far_reg, ref_pt);
					end
				end
			end
			default:
			begin
				state_next = IDLE;
			end
		endcase
		if (stop_cmd && state_reg != IDLE)
		begin
			state_next = IDLE;
			step_next  = 1'b0;
			pos_next   = pos_reg;
			abort_next = 1'b1;
			done_next  = 1'b0;
		end
		busy_next = state_next != IDLE;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= IDLE;
			mode_reg  <= MODE_RESET;
			dir_reg   <= 1'b0;
			fast_reg  <= 1'b1;
			step_reg  <= 1'b0;
			busy_reg  <= 1'b0;
			done_reg  <= 1'b0;
			abort_reg <= 1'b0;
			err_reg   <= 1'b0;
			pos_reg   <= POS_RESET;
			p1_reg    <= POS_RESET;
			far_reg   <= POS_RESET;
			dist_reg  <= POS_RESET;
			reply_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			mode_reg  <= mode_next;
			dir_reg   <= dir_next;
			fast_reg  <= fast_next;
			step_reg  <= step_next;
			busy_reg  <= busy_next;
			done_reg  <= done_next;
			abort_reg <= abort_next;
			err_reg   <= err_next;
			pos_reg   <= pos_next;
			p1_reg    <= p1_next;
			far_reg   <= far_next;
			dist_reg  <= dist_next;
			reply_reg <= reply_next;
		end
	end

	assign step_pulse      = step_reg;
	assign dir_out         = dir_reg;
	assign busy            = busy_reg;
	assign done            = done_reg;
	assign aborted         = abort_reg;
	assign mode_error      = err_reg;
	assign position        = pos_reg;
	assign switch_distance = dist_reg;
	assign reply           = reply_reg;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_foreign_code;
		cmd.valid && cmd.code != HOMING_CODE && !busy_reg |=> !busy_reg;
	endproperty
	a_foreign_code: assert property (p_foreign_code) else $error("foreign code started homing");

	property p_start_busy;
		start_cmd && state_reg == IDLE |=> busy_reg && !done_reg ##1 busy_reg || err_reg || abort_reg;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start not taken");

	property p_stop_halt;
		stop_cmd && state_reg != IDLE |=> !busy_reg && abort_reg && !step_reg ##1 !step_reg;
	endproperty
	a_stop_halt: assert property (p_stop_halt) else $error("stop did not halt axis");

	property p_search_speed;
		state_reg inside {SEEK_FAR, SEEK} |-> cur_speed == search_speed;
	endproperty
	a_search_speed: assert property (p_search_speed) else $error("search speed wrong");

	property p_calib_speed;
		state_reg inside {CAL_OUT, CAL_IN} |-> cur_speed == calib_speed;
	endproperty
	a_calib_speed: assert property (p_calib_speed) else $error("calibration speed wrong");

	property p_bad_mode;
		state_reg == START && !sel.ok |=> err_reg && !busy_reg && state_reg == IDLE;
	endproperty
	a_bad_mode: assert property (p_bad_mode) else $error("invalid mode accepted");

	property p_far_first;
		state_reg == SEEK_FAR |-> dir_reg == sel.dir_far && sel.two_stage;
	endproperty
	a_far_first: assert property (p_far_first) else $error("far switch leg wrong");

	property p_limit_rev;
		state_reg == SEEK && sel.use_limit && sel.limit && !sel.target && !stop_cmd
			|=> dir_reg != $past(sel.dir_tgt);
	endproperty
	a_limit_rev: assert property (p_limit_rev) else $error("no reversal at limit");

	property p_ignore_limits;
		state_reg == SEEK && !sel.use_limit && !sel.target |=> dir_reg == $past(dir_reg);
	endproperty
	a_ignore_limits: assert property (p_ignore_limits) else $error("limit changed search");

	property p_release_rev;
		state_reg == CAL_OUT && !sel.target && !stop_cmd
			|=> state_reg == CAL_IN && dir_reg != $past(dir_reg);
	endproperty
	a_release_rev: assert property (p_release_rev) else $error("no re-entry reversal");

	property p_step_pos;
		step_reg |-> position == ($past(dir_reg) ? $past(pos_reg) + POS_ONE
			: $past(pos_reg) - POS_ONE);
	endproperty
	a_step_pos: assert property (p_step_pos) else $error("position out of step");

	c_done_two: cover property (state_reg == CAL_IN ##1 done_reg && sel.two_stage);
	c_abort: cover property (stop_cmd && state_reg == SEEK ##1 abort_reg);
	c_bad_mode: cover property (state_reg == START ##1 err_reg);
	c_limit_rev: cover property (state_reg == SEEK && sel.use_limit && sel.limit);
endmodule

//--- core/homing_pkg.sv
/*
 Shared constants and carrier types for the axis homing block.
 Assumes one 100 MHz system clock; switch inputs already synchronous.
*/
package homing_pkg;
	localparam logic [7:0]  HOMING_CODE = 8'h0d;
	localparam logic [1:0]  OP_START    = 2'h0;
	localparam logic [1:0]  OP_STOP     = 2'h1;
	localparam logic [1:0]  OP_POLL     = 2'h2;
	localparam int          MIRROR_BIT  = 6;
	localparam int          INVERT_BIT  = 7;
	localparam int          SPEED_W     = 16;
	localparam int          POS_W       = 32;
	localparam logic [31:0] POS_RESET   = 32'h0000_0000;
	localparam logic [31:0] POS_ONE     = 32'h0000_0001;
	localparam logic [7:0]  MODE_RESET  = 8'h01;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
		logic [1:0] op;
	} cmd_s;

	typedef struct packed {
		logic valid;
		logic busy;
		logic done;
		logic aborted;
	} reply_s;

	// Mode-resolved view of the switches and the travel plan
	typedef struct packed {
		logic target;
		logic far;
		logic limit;
		logic dir_tgt;
		logic dir_far;
		logic centre;
		logic two_stage;
		logic use_limit;
		logic ok;
	} sel_s;
endpackage

//--- core/step_gen.sv
/*
 Step rate divider: phase accumulator that emits one-cycle step enables.
 Assumes speed is a fraction of the clock: rate = speed / 65536 * f_clk.
*/
`timescale 1ns/1ps
module step_gen (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic                           en,
	input  wire logic [homing_pkg::SPEED_W-1:0] speed,
	output logic                                tick
);
	import homing_pkg::*;

	logic [SPEED_W:0]   acc_sum;
	logic [SPEED_W-1:0] acc_reg;
	logic [SPEED_W-1:0] acc_next;
	logic               tick_reg;
	logic               tick_next;

	always_comb
	begin
		acc_sum   = {1'b0, acc_reg} + {1'b0, speed};
		acc_next  = en ? acc_sum[SPEED_W-1:0] : '0;
		tick_next = en & acc_sum[SPEED_W];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_reg  <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			acc_reg  <= acc_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule

//--- core/switch_pick.sv
/*
 Mode decoder: maps the latched search mode onto target, far and limit switches.
 Assumes switch levels are synchronous to the clock; purely combinational.
*/
`timescale 1ns/1ps
module switch_pick (
	input  wire logic [7:0]      mode,
	input  wire logic            sw_left,
	input  wire logic            sw_right,
	input  wire logic            sw_home,
	output homing_pkg::sel_s     sel
);
	import homing_pkg::*;

	logic       mir;
	logic       inv;
	logic       home;
	logic       lo;
	logic       hi;

	always_comb
	begin
		mir  = mode[MIRROR_BIT];
		inv  = mode[INVERT_BIT];
		home = sw_home ^ inv;
		lo   = mir ? sw_right : sw_left;
		hi   = mir ? sw_left : sw_right;
		sel  = '0;
		case (mode[5:0])
			6'h01:
			begin
				sel = '{target: lo, dir_tgt: mir, ok: !inv, default: 1'b0};
			end
			6'h02, 6'h03:
			begin
				sel = '{target: lo, far: hi, dir_tgt: mir, dir_far: !mir, two_stage: 1'b1,
					centre: mode[0], ok: !inv, default: 1'b0};
			end
			6'h04:
			begin
				sel = '{target: lo, dir_tgt: mir, centre: 1'b1, ok: !inv, default: 1'b0};
			end
			6'h05:
			begin
				sel = '{target: home, limit: sw_left, use_limit: 1'b1, ok: !mir,
					default: 1'b0};
			end
			6'h06:
			begin
				sel = '{target: home, limit: sw_right, dir_tgt: 1'b1, use_limit: 1'b1,
					ok: !mir, default: 1'b0};
			end
			6'h07:
			begin
				sel = '{target: home, dir_tgt: 1'b1, centre: 1'b1, ok: !mir,
					default: 1'b0};
			end
			6'h08:
			begin
				sel = '{target: home, centre: 1'b1, ok: !mir, default: 1'b0};
			end
			default:
			begin
				sel = '0;
			end
		endcase
	end
endmodule

//--- tb/axis_model.sv
/*
 Behavioural stepper axis: end switches and a home switch on a 200-step ring.
 Assumes step and direction come from the homing block, synchronous to clk.
*/
`timescale 1ns/1ps
module axis_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic step_pulse,
	input  wire logic dir_out,
	output logic      sw_left,
	output logic      sw_right,
	output logic      sw_home
);
	int mpos;
	int w;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mpos <= 0;
		else if (step_pulse)
			mpos <= dir_out ? mpos + 1 : mpos - 1;
	end

	// A ring, so a search that ignores the limits still meets the home switch
	always_comb
	begin
		w = ((mpos % 200) + 300) % 200 - 100;
		sw_left  = (w <= -40) && (w >= -50);
		sw_right = (w >= 40) && (w <= 50);
		sw_home  = (w >= 10) && (w <= 20);
	end
endmodule

//--- tb/homing_fsm_tb.sv
/*
 Self-checking bench for the homing sequencer, driving an axis model.
 Assumes search rate 1/4 and calibration rate 1/16 of the clock.
*/
`timescale 1ns/1ps
module homing_fsm_tb;
	import homing_pkg::*;
	localparam int N = 16;
	localparam int MODES [N] = '{1, 2, 3, 4, 5, 6, 7, 8, 65, 66, 67, 68, 133, 134, 135, 136};
	// Expected zero point in model steps and switch distance; 999 skips the compare
	localparam int REFS [N] = '{-40, -40, -45, -45, 10, 10, 15, -185, 40, 40, 45, 45,
		999, 999, 999, 999};
	localparam int DISTS [N] = '{999, 80, 85, 999, 999, 999, 999, 999, 999, 80, 85, 999,
		999, 999, 999, 999};
	logic                clk          = 1'b0;
	logic                rst_n        = 1'b0;
	cmd_s                cmd          = '0;
	logic [7:0]          search_mode  = 8'h01;
	logic [SPEED_W-1:0]  search_speed = 16'h4000;
	logic [SPEED_W-1:0]  calib_speed  = 16'h1000;
	logic                sw_left, sw_right, sw_home, step_pulse, dir_out;
	logic                busy, done, aborted, mode_error;
	logic [POS_W-1:0]    position, switch_distance;
	reply_s              reply;
	int                  miscompares  = 0;
	int                  comparisons  = 0;
	int                  cycles       = 0;

	homing_fsm i_dut (.clk(clk), .rst_n(rst_n), .cmd(cmd), .search_mode(search_mode),
		.search_speed(search_speed), .calib_speed(calib_speed), .sw_left(sw_left),
		.sw_right(sw_right), .sw_home(sw_home), .step_pulse(step_pulse), .dir_out(dir_out),
		.busy(busy), .done(done), .aborted(aborted), .mode_error(mode_error),
		.position(position), .switch_distance(switch_distance), .reply(reply));
	axis_model i_axis (.clk(clk), .rst_n(rst_n), .step_pulse(step_pulse), .dir_out(dir_out),
		.sw_left(sw_left), .sw_right(sw_right), .sw_home(sw_home));

	always #5 clk = ~clk;

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			miscompares++;
			close_out();
		end
	end

	task automatic close_out();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// Midpoint rounding and sampling leave a step or two of slack
	function automatic logic near(input logic [31:0] a, input int e);
		logic signed [31:0] d;
		d = $signed(a) - e;
		return (d >= -2) && (d <= 2);
	endfunction

	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
	endtask

	task automatic send(input logic [1:0] op, input logic [7:0] code, input logic [7:0] m);
		@(posedge clk);
		cmd <= '{1'b1, code, op};
		search_mode <= m;
		@(posedge clk);
		cmd <= '0;
		#1;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic wait_step(output int n);
		n = 0;
		do
		begin
			tick(1);
			n++;
		end
		while (step_pulse !== 1'b1 && n < 500);
	endtask

	task automatic t_modes();
		int n;
		for (int i = 0; i < N; i++)
		begin
			do_reset();
			send(OP_START, HOMING_CODE, 8'(MODES[i]));
			check("busy_start", busy, 1'b1);
			n = 0;
			while (done !== 1'b1 && n < 3000)
			begin
				tick(1);
				n++;
			end
			check("done", done, 1'b1);
			check("busy_end", busy, 1'b0);
			check("mode_err", mode_error, 1'b0);
			if (REFS[i] != 999)
				check("position", near(position, i_axis.mpos - REFS[i]), 1'b1);
			if (DISTS[i] != 999)
				check("distance", near(switch_distance, DISTS[i]), 1'b1);
		end
		send(OP_POLL, HOMING_CODE, 8'h01);
		check("poll_done", reply.done, 1'b1);
		check("poll_idle", reply.busy, 1'b0);
		$display("test modes finished");
	endtask

	task automatic t_speed();
		int g;
		do_reset();
		send(OP_START, HOMING_CODE, 8'h04);
		wait_step(g);
		wait_step(g);
		check("search_gap", g, 4);
		check("search_dir", dir_out, 1'b0);
		while (sw_left !== 1'b1)
			wait_step(g);
		wait_step(g);
		wait_step(g);
		check("calib_gap", g, 16);
		$display("test speed finished");
	endtask

	task automatic t_stop();
		logic [31:0] cnt;
		do_reset();
		send(OP_START, 8'h0e, 8'h07);
		check("wrong_code", busy, 1'b0);
		send(OP_START, HOMING_CODE, 8'h07);
		tick(20);
		send(OP_POLL, HOMING_CODE, 8'h07);
		check("poll_valid", reply.valid, 1'b1);
		check("poll_busy", reply.busy, 1'b1);
		send(OP_STOP, HOMING_CODE, 8'h07);
		check("stop_busy", busy, 1'b0);
		check("stop_abort", aborted, 1'b1);
		cnt = '0;
		for (int i = 0; i < 40; i++)
		begin
			tick(1);
			cnt = cnt + step_pulse;
		end
		check("stop_steps", cnt, 0);
		send(OP_POLL, HOMING_CODE, 8'h07);
		check("poll_abort", reply.aborted, 1'b1);
		tick(1);
		check("poll_pulse", reply.valid, 1'b0);
		$display("test stop finished");
	endtask

	task automatic t_invalid();
		logic [7:0] bad [4] = '{8'h00, 8'h09, 8'h45, 8'h81};
		for (int i = 0; i < 4; i++)
		begin
			send(OP_START, HOMING_CODE, bad[i]);
			check("bad_busy", busy, 1'b1);
			tick(1);
			check("bad_idle", busy, 1'b0);
			check("bad_flag", mode_error, 1'b1);
		end
		check("abort_clear", aborted, 1'b0);
		$display("test invalid finished");
	endtask

	initial
	begin
		do_reset();
		t_modes();
		t_speed();
		t_stop();
		t_invalid();
		close_out();
	end
endmodule
